/* File: core/nested_vector_irq_ctrl_arbiter.sv */
`timescale 1ns/100ps
`default_nettype none
// Picks the most urgent candidate; lowest level wins, then the lowest number.
module nic_arbiter #(
  parameter int unsigned N = nic_pkg::NUM_IRQ
) (
  // Candidates
  input wire logic [N-1:0] cand_i,
  input wire logic [N*nic_pkg::PRI_W-1:0] pri_i,
  // Result
  output var nic_pkg::nic_pick_t pick_o
);
  import nic_pkg::*;

  always_comb begin
    pick_o = '{found: 1'b0, id: '0, pri: PRI_IDLE};
    for (int i = N - 1; i >= 0; i--) begin
      if (cand_i[i] && (!pick_o.found || pri_i[i*PRI_W +: PRI_W] <= pick_o.pri)) begin // [RULE1] [RULE5]
        pick_o.found = 1'b1;
        pick_o.id = IRQ_ID_W'(i);
        pick_o.pri = pri_i[i*PRI_W +: PRI_W];
      end
    end
  end

endmodule : nic_arbiter
`default_nettype wire

/* File: core/nested_vector_irq_ctrl_ctrl.sv */
// How it works
// RULE1 - Each line has a two-bit level; zero is the most urgent.
// RULE2 - Level-held and pulsed requests are both detected on every line.
// RULE3 - There is no non-maskable input; only the 32 maskable lines exist.
// RULE4 - Enable-set: writing one enables, zero does nothing, read shows enables.
// RULE5 - A pending and enabled line is offered to the core by priority.
// RULE6 - A disabled line still goes pending but is never offered.
// RULE7 - Registers sit at fixed addresses and reset to zero.
// RULE8 - Only the two assigned private bus ranges are decoded.
// RULE9 - Sleep ends on an exception or a pending line that would preempt.
// RULE10 - A debug entry request ends sleep whether debug is enabled or not.
// RULE11 - Enable-clear: writing one disables, zero ignored, read shows enables.
// RULE12 - Pending-set: writing one makes the line pending, even if disabled.
// RULE13 - Pending-clear: writing one drops pending, active state untouched.
// RULE14 - Priority bytes keep only bits seven and six; the rest read zero.
// RULE15 - A pulse held one clock is latched until handler entry or clear.
`timescale 1ns/100ps
`default_nettype none
module nic_ctrl #(
  parameter int unsigned N = nic_pkg::NUM_IRQ
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Peripheral request lines, asynchronous to the core
  input wire logic [N-1:0] irq_req_i,
  // Private peripheral bus from the core
  input wire nic_pkg::nic_bus_req_t bus_req_i,
  output logic [31:0] bus_rdata_o,
  output logic bus_hit_o,
  // Core exception handshake
  input wire logic irq_ack_i,
  input wire logic [nic_pkg::IRQ_ID_W-1:0] irq_ack_id_i,
  input wire logic irq_exit_i,
  input wire logic [nic_pkg::IRQ_ID_W-1:0] irq_exit_id_i,
  input wire logic [nic_pkg::PRI_W-1:0] exec_pri_i,
  input wire logic exec_pri_valid_i,
  input wire logic global_irq_mask_i,
  input wire logic sys_exception_i,
  input wire logic debug_req_i,
  input wire logic sleep_req_i,
  // Offer to the core and wake-up
  output logic irq_take_o,
  output logic [nic_pkg::IRQ_ID_W-1:0] irq_take_id_o,
  output logic [nic_pkg::PRI_W-1:0] irq_take_pri_o,
  output logic sleeping_o,
  output logic wake_o
);
  import nic_pkg::*;

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------
  function automatic logic in_window(input logic [31:0] a);
    return (a >= WIN0_LO && a <= WIN0_HI) || (a >= WIN1_LO && a <= WIN1_HI); // [RULE8]
  endfunction : in_window

  function automatic logic is_pri_addr(input logic [31:0] a);
    return a >= ADDR_PRIORITY_BASE && a <= ADDR_PRIORITY_LAST && a[1:0] == 2'h0;
  endfunction : is_pri_addr

  logic [N-1:0] req_meta;
  logic [N-1:0] req_sync;
  logic [N-1:0] req_last;
  logic [N-1:0] enabled;
  logic [N-1:0] pending;
  logic [N-1:0] active;
  logic [N*PRI_W-1:0] prio;
  nic_state_t state;
  nic_pick_t pick;
  logic wr;
  logic [N-1:0] hw_set;
  logic [N-1:0] sw_set;
  logic [N-1:0] sw_clr;
  logic [N-1:0] ack_clr;
  logic [N-1:0] exit_bit;
  logic [2:0] pri_idx;
  logic would_preempt;
  logic wake_cond;

  // ----------------------------------------------------------------------
  // Request synchroniser and detection
  // ----------------------------------------------------------------------
  // No non-maskable path exists; every source goes through this gate. [RULE3]
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      req_meta <= '0;
      req_sync <= '0;
      req_last <= '0;
    end else begin
      req_meta <= irq_req_i;
      req_sync <= req_meta;
      req_last <= req_sync;
    end
  end

  // A held level re-pends once the line is no longer active; a rising edge pends
  // even while active, so a pulse during the handler is not lost. The entry cycle
  // counts as active, or a held level would survive its own handler entry.
  assign hw_set = (req_sync & ~active & ~ack_clr) | (req_sync & ~req_last); // [RULE2] [RULE15]

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  assign wr = bus_req_i.wr && in_window(bus_req_i.addr);
  assign sw_set = (wr && bus_req_i.addr == ADDR_PENDING_SET) ? bus_req_i.wdata[N-1:0] : '0; // [RULE12]
  assign sw_clr = (wr && bus_req_i.addr == ADDR_PENDING_CLEAR) ? bus_req_i.wdata[N-1:0] : '0; // [RULE13]
  assign ack_clr = irq_ack_i ? (N'(1) << irq_ack_id_i) : '0;
  assign exit_bit = irq_exit_i ? (N'(1) << irq_exit_id_i) : '0;
  assign pri_idx = bus_req_i.addr[4:2];

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      enabled <= RESET_VALUE[N-1:0]; // [RULE7]
    end else if (wr && bus_req_i.addr == ADDR_ENABLE_SET) begin
      enabled <= enabled | bus_req_i.wdata[N-1:0]; // [RULE4]
    end else if (wr && bus_req_i.addr == ADDR_ENABLE_CLEAR) begin
      enabled <= enabled & ~bus_req_i.wdata[N-1:0]; // [RULE11]
    end
  end

  // New requests win over a clear in the same cycle so no event is dropped.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      pending <= RESET_VALUE[N-1:0];
    end else begin
      pending <= (pending & ~sw_clr & ~ack_clr) | hw_set | sw_set; // [RULE6] [RULE12] [RULE15]
    end
  end

  // Pending-clear never touches this register.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      active <= '0;
    end else begin
      active <= (active & ~exit_bit) | ack_clr; // [RULE13]
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      prio <= '0; // [RULE7]
    end else if (wr && is_pri_addr(bus_req_i.addr)) begin
      for (int b = 0; b < 4; b++) begin
        prio[(pri_idx*4+b)*PRI_W +: PRI_W] <= bus_req_i.wdata[b*BYTE_W+PRI_LSB +: PRI_W]; // [RULE14]
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      bus_rdata_o <= RESET_VALUE;
      bus_hit_o <= 1'b0;
    end else begin
      bus_rdata_o <= RESET_VALUE;
      bus_hit_o <= (bus_req_i.rd || bus_req_i.wr) && in_window(bus_req_i.addr); // [RULE8]
      if (bus_req_i.rd && in_window(bus_req_i.addr)) begin
        if (bus_req_i.addr == ADDR_ENABLE_SET || bus_req_i.addr == ADDR_ENABLE_CLEAR) begin
          bus_rdata_o <= 32'(enabled); // [RULE4] [RULE11]
        end else if (bus_req_i.addr == ADDR_PENDING_SET || bus_req_i.addr == ADDR_PENDING_CLEAR) begin
          bus_rdata_o <= 32'(pending);
        end else if (is_pri_addr(bus_req_i.addr)) begin
          for (int b = 0; b < 4; b++) begin
            bus_rdata_o[b*BYTE_W+PRI_LSB +: PRI_W] <= prio[(pri_idx*4+b)*PRI_W +: PRI_W]; // [RULE14]
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Selection
  // ----------------------------------------------------------------------
  nic_arbiter #(
    .N(N)
  ) u_arb (
    .cand_i(pending & enabled & ~active), // [RULE5] [RULE6]
    .pri_i(prio),
    .pick_o(pick)
  );

  // Preemption needs a strictly more urgent level than the running one.
  assign would_preempt = pick.found && (!exec_pri_valid_i || pick.pri < exec_pri_i); // [RULE1]

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      irq_take_o <= 1'b0;
      irq_take_id_o <= '0;
      irq_take_pri_o <= PRI_RESET;
    end else begin
      irq_take_o <= would_preempt && !global_irq_mask_i && !irq_ack_i; // [RULE5]
      irq_take_id_o <= pick.id;
      irq_take_pri_o <= pick.pri;
    end
  end

  // ----------------------------------------------------------------------
  // Wait-for-interrupt sleep
  // ----------------------------------------------------------------------
  // The global mask is deliberately ignored here so a masked core still wakes.
  assign wake_cond = sys_exception_i || would_preempt || debug_req_i; // [RULE9] [RULE10]

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state <= NIC_RUN;
      sleeping_o <= 1'b0;
      wake_o <= 1'b0;
    end else begin
      wake_o <= 1'b0;
      unique case (state)
        NIC_RUN: begin
          if (sleep_req_i && !wake_cond) begin
            state <= NIC_SLEEP;
            sleeping_o <= 1'b1;
          end else if (sleep_req_i) begin
            wake_o <= 1'b1;
          end
        end
        NIC_SLEEP: begin
          if (wake_cond) begin // [RULE9] [RULE10]
            state <= NIC_RUN;
            sleeping_o <= 1'b0;
            wake_o <= 1'b1;
          end
        end
        default: begin
          state <= NIC_RUN;
          sleeping_o <= 1'b0;
        end
      endcase
    end
  end

endmodule : nic_ctrl
`default_nettype wire

/* File: core/nested_vector_irq_ctrl_pkg.sv */
`default_nettype none
package nic_pkg;

  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int unsigned NUM_IRQ = 32;
  localparam int unsigned PRI_W = 2;
  localparam int unsigned IRQ_ID_W = 5;
  localparam int unsigned PRI_REGS = 8;
  localparam int unsigned PRI_MSB = 7;
  localparam int unsigned PRI_LSB = 6;
  localparam int unsigned BYTE_W = 8;

  // ----------------------------------------------------------------------
  // Register map on the private peripheral bus
  // ----------------------------------------------------------------------
  localparam logic [31:0] ADDR_ENABLE_SET = 32'he000e100;
  localparam logic [31:0] ADDR_ENABLE_CLEAR = 32'he000e180;
  localparam logic [31:0] ADDR_PENDING_SET = 32'he000e200;
  localparam logic [31:0] ADDR_PENDING_CLEAR = 32'he000e280;
  localparam logic [31:0] ADDR_PRIORITY_BASE = 32'he000e400;
  localparam logic [31:0] ADDR_PRIORITY_LAST = 32'he000e41c;
  localparam logic [31:0] WIN0_LO = 32'he000e100;
  localparam logic [31:0] WIN0_HI = 32'he000e4ef;
  localparam logic [31:0] WIN1_LO = 32'he000ef00;
  localparam logic [31:0] WIN1_HI = 32'he000ef03;
  localparam logic [31:0] RESET_VALUE = 32'h00000000;
  localparam logic [PRI_W-1:0] PRI_RESET = 2'h0;
  localparam logic [PRI_W-1:0] PRI_IDLE = 2'h3;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic rd;
    logic wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } nic_bus_req_t;

  typedef struct packed {
    logic found;
    logic [IRQ_ID_W-1:0] id;
    logic [PRI_W-1:0] pri;
  } nic_pick_t;

  typedef enum logic [1:0] {
    NIC_RUN = 2'b00,
    NIC_SLEEP = 2'b01
  } nic_state_t;

endpackage : nic_pkg
`default_nettype wire

/* File: tb/nested_vector_irq_ctrl_core_model.sv */
`timescale 1ns/100ps
`default_nettype none
module nic_core_model (
  // Clock, reset and control
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic en_i,
  input wire logic [3:0] lat_i,
  // Offer from the controller
  input wire logic take_i,
  input wire logic [nic_pkg::IRQ_ID_W-1:0] take_id_i,
  // Handler entry and return
  output logic ack_o,
  output logic exit_o,
  output logic [nic_pkg::IRQ_ID_W-1:0] id_o
);
  import nic_pkg::*;
  // ----
  // One handler at a time; a long lat_i models a slow core.
  // ----
  logic busy;
  logic [3:0] cnt;
  always_ff @(posedge ref_clk_i) begin
    ack_o <= 1'b0;
    exit_o <= 1'b0;
    if (sys_rst_i) begin
      busy <= 1'b0;
      cnt <= 4'h0;
      id_o <= '0;
    end else if (!busy && en_i && take_i) begin
      ack_o <= 1'b1;
      id_o <= take_id_i;
      busy <= 1'b1;
      cnt <= lat_i;
    end else if (busy && cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else if (busy) begin
      exit_o <= 1'b1;
      busy <= 1'b0;
    end
  end
endmodule : nic_core_model
`default_nettype wire

/* File: tb/nested_vector_irq_ctrl_ctrl_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module nic_ctrl_assertions (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Register bus
  input wire nic_pkg::nic_bus_req_t bus_req_i,
  input wire logic [31:0] bus_rdata_o,
  input wire logic bus_hit_o,
  // Core side
  input wire logic irq_ack_i,
  input wire logic [nic_pkg::IRQ_ID_W-1:0] irq_ack_id_i,
  input wire logic global_irq_mask_i,
  input wire logic sys_exception_i,
  input wire logic debug_req_i,
  input wire logic irq_take_o,
  input wire logic [nic_pkg::IRQ_ID_W-1:0] irq_take_id_o,
  input wire logic sleeping_o,
  input wire logic wake_o
);
  import nic_pkg::*;
  // ----
  // A miss must look exactly like silence on the bus.
  // ----
  logic acc;
  logic in_win;
  assign acc = bus_req_i.rd | bus_req_i.wr;
  assign in_win = (bus_req_i.addr >= WIN0_LO && bus_req_i.addr <= WIN0_HI) ||
    (bus_req_i.addr >= WIN1_LO && bus_req_i.addr <= WIN1_HI);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  a_miss_silent: assert property (acc && !in_win |=> !bus_hit_o && bus_rdata_o == RESET_VALUE)
    else $error("miss was answered");
  a_window_hit: assert property (acc && in_win |=> bus_hit_o)
    else $error("window access not hit");
  a_mask_blocks: assert property (global_irq_mask_i |=> !irq_take_o)
    else $error("offer while masked");
  a_debug_wakes: assert property (sleeping_o && debug_req_i |=> wake_o && !sleeping_o)
    else $error("debug request did not wake");
  a_exc_wakes: assert property (sleeping_o && sys_exception_i |=> wake_o && !sleeping_o)
    else $error("exception did not wake");
  a_wake_pulse: assert property (wake_o |=> !wake_o)
    else $error("wake longer than one cycle");
  a_ack_drops: assert property (irq_ack_i && irq_take_o |=>
    !irq_take_o || irq_take_id_o != $past(irq_ack_id_i))
    else $error("offer stayed after entry");
  a_reset_clears: assert property (disable iff (1'b0)
    sys_rst_i |=> !irq_take_o && !sleeping_o && !wake_o && !bus_hit_o)
    else $error("outputs not cleared by reset");
  c_entry: cover property (irq_take_o && irq_ack_i);
  c_wake: cover property (wake_o);
  c_miss: cover property (acc && !in_win);
endmodule : nic_ctrl_assertions
`default_nettype wire

/* File: tb/nested_vector_irq_ctrl_ctrl_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module nic_ctrl_tb_top;
  import nic_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] irq = '0;
  nic_bus_req_t breq = '0;
  logic mask = 1'b0;
  logic exc = 1'b0;
  logic dbg = 1'b0;
  logic slp = 1'b0;
  logic epv = 1'b0;
  logic en = 1'b0;
  logic [31:0] rdata, rv;
  logic [4:0] tid, aid;
  logic [1:0] tpri;
  logic hit, hv, ack, ext, take, sleeping, wake;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  always #50 clk = ~clk;
  nic_ctrl nic_ctrl_i (.ref_clk_i(clk), .sys_rst_i(rst), .irq_req_i(irq), .bus_req_i(breq),
    .bus_rdata_o(rdata), .bus_hit_o(hit), .irq_ack_i(ack), .irq_ack_id_i(aid), .irq_exit_i(ext),
    .irq_exit_id_i(aid), .exec_pri_i(2'h0), .exec_pri_valid_i(epv), .global_irq_mask_i(mask),
    .sys_exception_i(exc), .debug_req_i(dbg), .sleep_req_i(slp), .irq_take_o(take),
    .irq_take_id_o(tid), .irq_take_pri_o(tpri), .sleeping_o(sleeping), .wake_o(wake));
  nic_core_model nic_core_model_i (.ref_clk_i(clk), .sys_rst_i(rst), .en_i(en), .lat_i(4'h6),
    .take_i(take), .take_id_i(tid), .ack_o(ack), .exit_o(ext), .id_o(aid));
  // ----
  // Tasks; outputs are sampled 1 ns after an edge so its updates have landed.
  // ----
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    breq <= '{rd: !w, wr: w, addr: a, wdata: d};
    @(posedge clk);
    breq <= '0;
    #1;
    rv = rdata;
    hv = hit;
  endtask : acc
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic t_reset;
    logic [31:0] adr [6];
    adr = '{ADDR_ENABLE_SET, ADDR_ENABLE_CLEAR, ADDR_PENDING_SET, ADDR_PENDING_CLEAR, ADDR_PRIORITY_BASE,
      ADDR_PRIORITY_LAST};
    foreach (adr[i]) begin
      acc(1'b0, adr[i], '0);
      chk("reset value", rv, RESET_VALUE);
      chk("window hit", {31'h0, hv}, 32'h1);
    end
    acc(1'b0, WIN0_LO - 32'h4, '0);
    chk("miss hit", {31'h0, hv}, 32'h0);
    acc(1'b0, WIN1_LO, '0);
    chk("second window hit", {31'h0, hv}, 32'h1);
  endtask : t_reset
  task automatic t_regs;
    acc(1'b1, ADDR_ENABLE_SET, 32'h000000a5);
    acc(1'b1, ADDR_ENABLE_SET, 32'h0);
    acc(1'b0, ADDR_ENABLE_SET, '0);
    chk("enable set", rv, 32'h000000a5);
    acc(1'b1, ADDR_ENABLE_CLEAR, 32'h00000021);
    acc(1'b0, ADDR_ENABLE_CLEAR, '0);
    chk("enable clear", rv, 32'h00000084);
    acc(1'b1, ADDR_ENABLE_CLEAR, 32'hffffffff);
    acc(1'b1, ADDR_PRIORITY_BASE, 32'hffffffff);
    acc(1'b0, ADDR_PRIORITY_BASE, '0);
    chk("priority bits", rv, 32'hc0c0c0c0);
    acc(1'b1, ADDR_PRIORITY_LAST, 32'h7fbfff3f);
    acc(1'b0, ADDR_PRIORITY_LAST, '0);
    chk("priority levels", rv, 32'h4080c000);
  endtask : t_regs
  task automatic t_pend;
    @(posedge clk);
    irq <= 32'h1;
    cyc(4);
    chk("disabled offer", {31'h0, take}, 32'h0);
    acc(1'b0, ADDR_PENDING_SET, '0);
    chk("level pends", rv, 32'h1);
    @(posedge clk);
    irq <= '0;
    cyc(4);
    acc(1'b1, ADDR_PENDING_CLEAR, 32'h1);
    acc(1'b0, ADDR_PENDING_CLEAR, '0);
    chk("pending clear", rv, 32'h0);
    acc(1'b1, ADDR_PENDING_SET, 32'h2);
    acc(1'b1, ADDR_PENDING_SET, 32'h2);
    acc(1'b0, ADDR_PENDING_SET, '0);
    chk("software pend", rv, 32'h2);
    acc(1'b1, ADDR_PENDING_CLEAR, 32'h2);
  endtask : t_pend
  task automatic wait_id(input logic [4:0] id);
    for (int i = 0; i < 40 && !(take === 1'b1 && tid === id); i++) begin
      @(posedge clk);
      #1;
    end
    chk("offered id", {26'h0, take, tid}, {26'h0, 1'b1, id});
  endtask : wait_id
  task automatic t_arb;
    @(posedge clk);
    mask <= 1'b1;
    irq <= 32'ha0000001;
    @(posedge clk);
    irq <= '0;
    acc(1'b1, ADDR_ENABLE_SET, 32'ha0000001);
    cyc(4);
    chk("masked offer", {31'h0, take}, 32'h0);
    @(posedge clk);
    mask <= 1'b0;
    cyc(3);
    chk("urgent offer", {24'h0, take, tpri, tid}, {24'h0, 1'b1, 2'h1, 5'd31});
    @(posedge clk);
    en <= 1'b1;
    wait_id(5'd0);
    wait_id(5'd29);
    cyc(20);
    acc(1'b0, ADDR_PENDING_SET, '0);
    chk("pending after entry", rv, 32'h0);
    acc(1'b1, ADDR_ENABLE_CLEAR, 32'hffffffff);
  endtask : t_arb
  // A held level is dropped on entry, pends again after return, and stops once released.
  task automatic t_level;
    acc(1'b1, ADDR_ENABLE_SET, 32'h4);
    @(posedge clk);
    irq <= 32'h4;
    wait_id(5'd2);
    cyc(2);
    acc(1'b0, ADDR_PENDING_SET, '0);
    chk("level cleared on entry", rv, 32'h0);
    wait_id(5'd2);
    @(posedge clk);
    irq <= '0;
    cyc(20);
    acc(1'b0, ADDR_PENDING_SET, '0);
    chk("level released", rv, 32'h0);
    acc(1'b1, ADDR_ENABLE_CLEAR, 32'hffffffff);
  endtask : t_level
  task automatic nap(input int k);
    @(posedge clk);
    slp <= 1'b1;
    @(posedge clk);
    slp <= 1'b0;
    #1;
    chk("sleep entry", {31'h0, sleeping}, 32'h1);
    @(posedge clk);
    dbg <= (k == 0);
    exc <= (k == 1);
    mask <= (k == 2);
    irq <= (k == 2) ? 32'h20 : 32'h0;
    @(posedge clk);
    dbg <= 1'b0;
    exc <= 1'b0;
    irq <= '0;
    #1;
    for (int i = 0; i < 8 && wake !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    rv = {30'h0, wake, sleeping};
  endtask : nap
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_pend();
    t_arb();
    t_level();
    nap(0);
    chk("debug wake", rv, 32'h2);
    nap(1);
    chk("exception wake", rv, 32'h2);
    acc(1'b1, ADDR_ENABLE_SET, 32'h20);
    nap(2);
    chk("pending wake", rv, 32'h2);
    @(posedge clk);
    epv <= 1'b1;
    nap(3);
    chk("level not preempting", rv, 32'h1);
    @(posedge clk);
    epv <= 1'b0;
    cyc(1);
    chk("preempt wake", {30'h0, wake, sleeping}, 32'h2);
    summarize();
  end
endmodule : nic_ctrl_tb_top
bind nic_ctrl nic_ctrl_assertions nic_ctrl_assertions_i (.ref_clk_i, .sys_rst_i, .bus_req_i,
  .bus_rdata_o, .bus_hit_o, .irq_ack_i, .irq_ack_id_i, .global_irq_mask_i, .sys_exception_i,
  .debug_req_i, .irq_take_o, .irq_take_id_o, .sleeping_o, .wake_o);
`default_nettype wire
